/* File: core/ett_pkg.sv */
// Constants, types and the configuration decoder of the ETU timeout counter.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz system clock.
package ett_pkg;

   // ==========================================================================
   // Register map (byte addresses)
   // ==========================================================================
   localparam int ETT_ADDR_W = 5;
   localparam logic [4:0] ETT_OFF_CONFIG = 5'h00;
   localparam logic [4:0] ETT_OFF_RELOAD_LOW = 5'h04;
   localparam logic [4:0] ETT_OFF_RELOAD_MID = 5'h08;
   localparam logic [4:0] ETT_OFF_RELOAD_HIGH = 5'h0c;
   localparam logic [4:0] ETT_OFF_DIVIDER = 5'h10;
   localparam logic [4:0] ETT_OFF_STATUS = 5'h14;
   localparam logic [4:0] ETT_OFF_COUNT = 5'h18;

   // ==========================================================================
   // Field positions and reset values
   // ==========================================================================
   localparam int ETT_DIV_PRESCALE_BIT = 8;
   localparam int ETT_STAT_LOW_BIT = 0;
   localparam int ETT_STAT_UP_BIT = 1;
   localparam int ETT_STAT_LOW_RUN_BIT = 2;
   localparam int ETT_STAT_UP_RUN_BIT = 3;
   localparam logic [7:0] ETT_RST_BYTE = 8'h00;
   localparam logic [1:0] ETT_RESP_OKAY = 2'h0;
   localparam logic [1:0] ETT_RESP_SLVERR = 2'h2;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int ETT_PRESCALE_SHORT = 31;
   localparam int ETT_PRESCALE_LONG = 32;
   localparam logic [3:0] ETT_AUTOSTOP_ETUS = 4'hc;

   // ==========================================================================
   // Configuration codes
   // ==========================================================================
   localparam logic [7:0] ETT_CODE_STOP = 8'h00;
   localparam logic [7:0] ETT_CODE_LOW_RELOAD = 8'h05;
   localparam logic [7:0] ETT_CODE_SOFT16 = 8'h61;
   localparam logic [7:0] ETT_CODE_SOFT16_RELOAD = 8'h65;
   localparam logic [7:0] ETT_CODE_SOFT24 = 8'h68;
   localparam logic [7:0] ETT_CODE_START16 = 8'h71;
   localparam logic [7:0] ETT_CODE_START16_RELOAD = 8'h75;
   localparam logic [7:0] ETT_CODE_START24 = 8'h7c;
   localparam logic [7:0] ETT_CODE_LOW_AUTO = 8'h85;
   localparam logic [7:0] ETT_CODE_SOFT16_AUTO = 8'he5;
   localparam logic [7:0] ETT_CODE_AUTO16 = 8'hf1;
   localparam logic [7:0] ETT_CODE_AUTO16_AUTO = 8'hf5;

   // Auto means autostop when receiving; when transmitting the lower stage
   // reloads and the upper stage behaves as plain start-bit mode.
   typedef enum logic [3:0] {
      ETT_STOP = 4'b0001,
      ETT_SOFT = 4'b0010,
      ETT_START = 4'b0100,
      ETT_AUTO = 4'b1000
   } ett_mode_e;

   typedef struct packed {
      ett_mode_e low;
      ett_mode_e up;
      logic join24;
   } ett_cfg_s;

   function automatic ett_cfg_s ett_decode(input logic [7:0] code);
      ett_cfg_s c;
      c = '{low: ETT_STOP, up: ETT_STOP, join24: 1'b0};
      case (code)
         ETT_CODE_LOW_RELOAD: c.low = ETT_START;
         ETT_CODE_SOFT16: c.up = ETT_SOFT;
         ETT_CODE_SOFT16_RELOAD: c = '{low: ETT_START, up: ETT_SOFT, join24: 1'b0};
         ETT_CODE_SOFT24: c = '{low: ETT_STOP, up: ETT_SOFT, join24: 1'b1};
         ETT_CODE_START16: c.up = ETT_START;
         ETT_CODE_START16_RELOAD: c = '{low: ETT_START, up: ETT_START, join24: 1'b0};
         ETT_CODE_START24: c = '{low: ETT_STOP, up: ETT_START, join24: 1'b1};
         ETT_CODE_LOW_AUTO: c.low = ETT_AUTO;
         ETT_CODE_SOFT16_AUTO: c = '{low: ETT_AUTO, up: ETT_SOFT, join24: 1'b0};
         ETT_CODE_AUTO16: c.up = ETT_AUTO;
         ETT_CODE_AUTO16_AUTO: c = '{low: ETT_AUTO, up: ETT_AUTO, join24: 1'b0};
         default: c = '{low: ETT_STOP, up: ETT_STOP, join24: 1'b0};
      endcase
      return c;
   endfunction : ett_decode

endpackage : ett_pkg

/* File: core/ett_etu_tick.sv */
// ETU tick generator: card clock enable, prescaler of 31 or 32, then an
// autoreload divider. Assumes card_clk_en is a one-cycle pulse on aclk.
`timescale 1ns/1ns
module ett_etu_tick import ett_pkg::*; #(
   parameter int DIV_W = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic card_clk_en,
   input wire logic prescale_long,
   input wire logic [DIV_W-1:0] etu_divider,
   // Tick out
   output logic etu_tick
);

   initial begin
      if (DIV_W < 1 || DIV_W > 16) $error("ett_etu_tick: DIV_W out of range");
   end

   logic [5:0] pre_cnt;
   logic [DIV_W-1:0] div_cnt;

   wire [5:0] pre_last = prescale_long ? 6'(ETT_PRESCALE_LONG - 1) : 6'(ETT_PRESCALE_SHORT - 1);
   wire pre_wrap = card_clk_en && (pre_cnt >= pre_last);
   wire div_wrap = pre_wrap && (div_cnt == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) pre_cnt <= 6'h00;
      else if (pre_wrap) pre_cnt <= 6'h00;
      else if (card_clk_en) pre_cnt <= pre_cnt + 6'h01;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) div_cnt <= '0;
      else if (div_wrap) div_cnt <= etu_divider;
      else if (pre_wrap) div_cnt <= div_cnt - 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) etu_tick <= 1'b0;
      else etu_tick <= div_wrap;
   end

endmodule : ett_etu_tick

/* File: core/ett_timeout_counter.sv */
// ETU timeout counter: three 8-bit stages as 8+16 or 24 bits, AXI4-Lite slave.
// Assumes card_io_line, receive_direction and card_active are synchronous to
// aclk and that the card clock arrives as the one-cycle enable card_clk_en.
`timescale 1ns/1ns
module ett_timeout_counter import ett_pkg::*; #(
   parameter int DIV_W = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [ETT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ETT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Card side
   input wire logic card_clk_en,
   input wire logic card_active,
   input wire logic card_io_line,
   input wire logic receive_direction,
   // Host notification
   output logic timeout_irq
);

   initial begin
      if (DIV_W != 8) $error("ett_timeout_counter: DIV_W must be 8");
   end

   // ==========================================================================
   // Register bus
   // ==========================================================================
   logic aw_hold;
   logic w_hold;
   logic [ETT_ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [7:0] timeout_config;
   logic [7:0] timeout_reload_low;
   logic [7:0] timeout_reload_mid;
   logic [7:0] timeout_reload_high;
   logic [DIV_W-1:0] etu_divider;
   logic prescale_long;
   logic low_flag;
   logic up_flag;
   logic [7:0] low_cnt;
   logic [15:0] up_cnt;
   logic low_run;
   logic up_run;

   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire do_wr = aw_hold && w_hold && !s_axi_bvalid;
   wire wr_lane0 = do_wr && wr_strb[0];
   wire wr_lane1 = do_wr && wr_strb[1];
   wire wr_mapped = wr_addr <= ETT_OFF_COUNT && wr_addr[1:0] == 2'h0;
   wire cfg_wr = wr_lane0 && wr_addr == ETT_OFF_CONFIG;
   wire stat_wr = wr_lane0 && wr_addr == ETT_OFF_STATUS;
   wire rd_take = s_axi_arvalid && s_axi_arready;
   wire rd_mapped = s_axi_araddr <= ETT_OFF_COUNT && s_axi_araddr[1:0] == 2'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         wr_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_hold <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (do_wr) begin
         w_hold <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ETT_RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? ETT_RESP_OKAY : ETT_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Reload values only feed the counters at a load, so a write here never
   // disturbs a count in progress, though a config write here can.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timeout_config <= ETT_RST_BYTE;
         timeout_reload_low <= ETT_RST_BYTE;
         timeout_reload_mid <= ETT_RST_BYTE;
         timeout_reload_high <= ETT_RST_BYTE;
         etu_divider <= '0;
         prescale_long <= 1'b0;
      end else begin
         if (cfg_wr) timeout_config <= wr_data[7:0];
         if (wr_lane0 && wr_addr == ETT_OFF_RELOAD_LOW) timeout_reload_low <= wr_data[7:0];
         if (wr_lane0 && wr_addr == ETT_OFF_RELOAD_MID) timeout_reload_mid <= wr_data[7:0];
         if (wr_lane0 && wr_addr == ETT_OFF_RELOAD_HIGH) timeout_reload_high <= wr_data[7:0];
         if (wr_lane0 && wr_addr == ETT_OFF_DIVIDER) etu_divider <= wr_data[DIV_W-1:0];
         if (wr_lane1 && wr_addr == ETT_OFF_DIVIDER) prescale_long <= wr_data[ETT_DIV_PRESCALE_BIT];
      end
   end

   wire [31:0] rd_word =
      (s_axi_araddr == ETT_OFF_CONFIG) ? {24'h0, timeout_config} :
      (s_axi_araddr == ETT_OFF_RELOAD_LOW) ? {24'h0, timeout_reload_low} :
      (s_axi_araddr == ETT_OFF_RELOAD_MID) ? {24'h0, timeout_reload_mid} :
      (s_axi_araddr == ETT_OFF_RELOAD_HIGH) ? {24'h0, timeout_reload_high} :
      (s_axi_araddr == ETT_OFF_DIVIDER) ? {23'h0, prescale_long, etu_divider} :
      (s_axi_araddr == ETT_OFF_STATUS) ? {28'h0, up_run, low_run, up_flag, low_flag} :
      (s_axi_araddr == ETT_OFF_COUNT) ? {8'h0, up_cnt, low_cnt} : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ETT_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_mapped ? ETT_RESP_OKAY : ETT_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // ETU tick and start bit detection
   // ==========================================================================
   logic etu_tick_raw;
   logic io_prev;

   ett_etu_tick #(.DIV_W(DIV_W)) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .card_clk_en(card_clk_en),
      .prescale_long(prescale_long),
      .etu_divider(etu_divider),
      .etu_tick(etu_tick_raw)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) io_prev <= 1'b1;
      else io_prev <= card_io_line;
   end

   // No stage counts unless the card is powered and clocked; start bits are seen only while it is powered.
   wire tick = etu_tick_raw && card_active;
   wire start_bit = card_active && io_prev && !card_io_line;

   // ==========================================================================
   // Counter stages
   // ==========================================================================
   wire ett_cfg_s cfg = ett_decode(timeout_config);
   wire ett_cfg_s new_cfg = ett_decode(wr_data[7:0]);
   wire [23:0] wide_cnt = {up_cnt, low_cnt};
   wire low_alone = !cfg.join24 && cfg.low != ETT_STOP;
   wire low_reloads = cfg.low == ETT_START || (cfg.low == ETT_AUTO && !receive_direction);
   wire low_tc = tick && low_run && !cfg.join24 && low_cnt <= 8'h01;
   wire up_tc = tick && up_run && (cfg.join24 ? wide_cnt <= 24'h1 : up_cnt <= 16'h0001);
   wire up_on_start = cfg.up == ETT_START || cfg.up == ETT_AUTO;
   wire soft_keep = cfg.up == ETT_SOFT && up_run && new_cfg.up == ETT_SOFT
      && new_cfg.join24 == cfg.join24;

   // Twelve-ETU window after the first received start bit.
   logic win_on;
   logic [3:0] win_cnt;
   wire win_need = receive_direction && ((low_alone && cfg.low == ETT_AUTO) || cfg.up == ETT_AUTO);
   wire win_end = tick && win_on && win_cnt == ETT_AUTOSTOP_ETUS - 4'h1;
   wire auto_stop = win_end && receive_direction;

   always_ff @(posedge aclk) begin
      if (!aresetn || cfg_wr) begin
         win_on <= 1'b0;
         win_cnt <= 4'h0;
      end else if (!win_on && start_bit && win_need) begin
         win_on <= 1'b1;
         win_cnt <= 4'h0;
      end else if (win_end) begin
         win_on <= 1'b0;
      end else if (win_on && tick) begin
         win_cnt <= win_cnt + 4'h1;
      end
   end

   logic [7:0] next_low_cnt;
   logic [15:0] next_up_cnt;
   logic next_low_run;
   logic next_up_run;

   always_comb begin
      next_low_cnt = low_cnt;
      next_up_cnt = up_cnt;
      next_low_run = low_run;
      next_up_run = up_run;
      // Lower stage on its own.
      if (low_tc) begin
         if (low_reloads) begin
            next_low_cnt = timeout_reload_low;
         end else begin
            next_low_cnt = 8'h00;
            next_low_run = 1'b0;
         end
      end else if (tick && low_run && !cfg.join24) begin
         next_low_cnt = low_cnt - 8'h01;
      end
      if (auto_stop && low_alone && cfg.low == ETT_AUTO) next_low_run = 1'b0;
      // The lower stage ignores later start bits while it runs.
      if (start_bit && low_alone && !low_run) begin
         next_low_cnt = timeout_reload_low;
         next_low_run = 1'b1;
      end
      // Upper stage, or all three stages joined.
      if (up_tc) begin
         next_up_run = 1'b0;
         next_up_cnt = 16'h0000;
         if (cfg.join24) next_low_cnt = 8'h00;
      end else if (tick && up_run) begin
         if (cfg.join24) {next_up_cnt, next_low_cnt} = wide_cnt - 24'h1;
         else next_up_cnt = up_cnt - 16'h0001;
      end
      if (auto_stop && cfg.up == ETT_AUTO) next_up_run = 1'b0;
      if (start_bit && up_on_start) begin
         next_up_cnt = {timeout_reload_high, timeout_reload_mid};
         next_up_run = 1'b1;
         if (cfg.join24) next_low_cnt = timeout_reload_low;
      end
      // A new code stops, starts or leaves alone each stage.
      if (cfg_wr) begin
         if (new_cfg.low == ETT_STOP || new_cfg.join24) next_low_run = 1'b0;
         if (new_cfg.up == ETT_STOP) begin
            next_up_run = 1'b0;
         end else if (new_cfg.up == ETT_SOFT) begin
            if (!soft_keep) begin
               next_up_cnt = {timeout_reload_high, timeout_reload_mid};
               next_up_run = 1'b1;
               if (new_cfg.join24) next_low_cnt = timeout_reload_low;
            end
         end else if (cfg.up == ETT_SOFT || new_cfg.join24 != cfg.join24) begin
            next_up_run = 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_cnt <= 8'h00;
         up_cnt <= 16'h0000;
         low_run <= 1'b0;
         up_run <= 1'b0;
      end else begin
         low_cnt <= next_low_cnt;
         up_cnt <= next_up_cnt;
         low_run <= next_low_run;
         up_run <= next_up_run;
      end
   end

   // ==========================================================================
   // Timeout flags
   // ==========================================================================
   // A terminal count in the same cycle as a clear wins, so no timeout is lost.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_flag <= 1'b0;
         up_flag <= 1'b0;
      end else begin
         low_flag <= low_tc || (low_flag && !(stat_wr && wr_data[ETT_STAT_LOW_BIT]));
         up_flag <= up_tc || (up_flag && !(stat_wr && wr_data[ETT_STAT_UP_BIT]));
      end
   end

   assign timeout_irq = low_flag || up_flag;

endmodule : ett_timeout_counter

/* File: bench/ett_tc_assertions.sv */
// Checker for the ETU timeout counter: bus handshakes and timeout notification.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/1ns
module ett_tc_assertions import ett_pkg::*; #(
   parameter int DIV_W = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic [ETT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ETT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Card side and notification
   input wire logic card_clk_en,
   input wire logic card_active,
   input wire logic card_io_line,
   input wire logic receive_direction,
   input wire logic timeout_irq
);
   // ==========================================================================
   // Properties
   // ==========================================================================
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence bad_read;
      s_axi_arvalid && s_axi_arready &&
         (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > ETT_OFF_COUNT);
   endsequence
   AST_WRITE_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted during data");
   AST_BAD_READ: assert property (bad_read |=> s_axi_rresp == ETT_RESP_SLVERR &&
      s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   // Flags only fall on a write answer, since only a status write clears them.
   AST_IRQ_CLEAR: assert property ($fell(timeout_irq) |-> $rose(s_axi_bvalid))
      else $error("timeout notice dropped without a write");
   AST_IRQ_FROZEN: assert property (!card_active [*4] |-> !$rose(timeout_irq))
      else $error("timeout while card inactive");
endmodule : ett_tc_assertions

bind ett_timeout_counter ett_tc_assertions #(.DIV_W(DIV_W)) ett_tc_assertions_inst (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .card_clk_en(card_clk_en), .card_active(card_active),
   .card_io_line(card_io_line), .receive_direction(receive_direction),
   .timeout_irq(timeout_irq));

/* File: bench/ett_card_model.sv */
// Card-side model: card clock enable and the card I/O line.
// Assumes the bench calls start_bit from its main sequence.
`timescale 1ns/1ns
module ett_card_model (
   // Clock
   input wire logic aclk,
   // Card side
   output logic card_clk_en,
   output logic card_io_line
);
   // ==========================================================================
   // Card clock and line
   // ==========================================================================
   initial begin
      card_clk_en = 1'b0;
      card_io_line = 1'b1;
   end
   // Half the system rate, so one ETU is twice the prescale count.
   always @(posedge aclk) begin
      card_clk_en <= ~card_clk_en;
   end
   // The line rests high through its pull-up; a start bit pulls it low.
   task automatic start_bit();
      @(posedge aclk);
      card_io_line <= 1'b0;
      repeat (8) @(posedge aclk);
      card_io_line <= 1'b1;
   endtask : start_bit
endmodule : ett_card_model

/* File: bench/testbench.sv */
// Self-checking bench for the ETU timeout counter over AXI4-Lite.
// Assumes the package, the design, the card model and the checker compile first.
`timescale 1ns/1ns
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module testbench import ett_pkg::*; ();
   // ==========================================================================
   // Signals and instances
   // ==========================================================================
   localparam int ETU = 62;
   localparam logic [1:0] OK = ETT_RESP_OKAY;
   // Code, direction, low, mid, status after fourteen ETUs.
   localparam logic [39:0] TBL [11] = '{40'h05_01_02_00_05, 40'h85_01_20_00_00,
      40'h85_00_02_00_05, 40'hf5_01_20_20_00, 40'hf1_01_00_20_00, 40'hf1_00_00_20_08,
      40'h75_00_02_20_0d, 40'h7c_01_20_00_08, 40'h33_01_02_02_00, 40'he5_01_20_20_08,
      40'h65_00_02_20_0d};
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, card_clk_en, card_active, card_io_line, receive_direction;
   logic timeout_irq;
   logic [ETT_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   ett_timeout_counter #(.DIV_W(8)) ett_timeout_counter_inst (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .card_clk_en(card_clk_en), .card_active(card_active), .card_io_line(card_io_line),
      .receive_direction(receive_direction), .timeout_irq(timeout_irq));
   ett_card_model ett_card_model_inst (.aclk(aclk), .card_clk_en(card_clk_en),
      .card_io_line(card_io_line));
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // ==========================================================================
   // Bus tasks and closing
   // ==========================================================================
   task automatic wr(input logic [ETT_ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      logic aw, wd;
      aw = 1'b0;
      wd = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && wd)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      `CHK(s_axi_bresp, e)
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ETT_ADDR_W-1:0] a, input logic [31:0] x,
                     input logic [1:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      `CHK(s_axi_rresp, e)
      `CHK(s_axi_rdata, x)
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic wait_irq(output int n);
      n = 0;
      while (timeout_irq !== 1'b1 && n < 4000) begin
         @(posedge aclk);
         n++;
      end
   endtask : wait_irq
   task automatic end_of_test();
      $display("Checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   // A hang anywhere ends the run as a failure.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      int n;
      logic [39:0] t;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      card_active = 1'b0;
      receive_direction = 1'b0;
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      card_active <= 1'b1;
      `CHK(timeout_irq, 1'b0)
      rd(ETT_OFF_CONFIG, 32'h0, OK);
      rd(5'h1c, 32'h0, ETT_RESP_SLVERR);
      wr(5'h1c, 32'h0, ETT_RESP_SLVERR);
      wr(ETT_OFF_DIVIDER, 32'h0, OK);
      wr(ETT_OFF_RELOAD_MID, 32'h3, OK);
      wr(ETT_OFF_CONFIG, {24'h0, ETT_CODE_SOFT16}, OK);
      card_active <= 1'b0;
      repeat (3 * ETU) @(posedge aclk);
      card_active <= 1'b1;
      wait_irq(n);
      `CHK(n inside {[ETU:3*ETU+4]}, 1'b1)
      rd(ETT_OFF_STATUS, 32'h2, OK);
      rd(ETT_OFF_COUNT, 32'h0, OK);
      wr(ETT_OFF_STATUS, 32'h2, OK);
      `CHK(timeout_irq, 1'b0)
      wr(ETT_OFF_RELOAD_LOW, 32'hff, OK);
      wr(ETT_OFF_CONFIG, {24'h0, ETT_CODE_SOFT24}, OK);
      repeat (ETU) @(posedge aclk);
      rd(ETT_OFF_STATUS, 32'h8, OK);
      wr(ETT_OFF_CONFIG, 32'h0, OK);
      rd(ETT_OFF_STATUS, 32'h0, OK);
      wr(ETT_OFF_RELOAD_MID, 32'h2, OK);
      wr(ETT_OFF_CONFIG, {24'h0, ETT_CODE_START16}, OK);
      ett_card_model_inst.start_bit();
      wr(ETT_OFF_RELOAD_MID, 32'h9, OK);
      wait_irq(n);
      `CHK(n inside {[ETU:2*ETU+16]}, 1'b1)
      rd(ETT_OFF_STATUS, 32'h2, OK);
      wr(ETT_OFF_STATUS, 32'h2, OK);
      repeat (2) begin
         ett_card_model_inst.start_bit();
         rd(ETT_OFF_STATUS, 32'h8, OK);
         repeat (4 * ETU) @(posedge aclk);
      end
      // The low byte still holds what the 24-bit count left after its one ETU.
      rd(ETT_OFF_COUNT, 32'h05fe, OK);
      wr(ETT_OFF_CONFIG, 32'h0, OK);
      wr(ETT_OFF_RELOAD_HIGH, 32'h0, OK);
      for (int i = 0; i < 11; i++) begin
         t = TBL[i];
         receive_direction <= t[24];
         wr(ETT_OFF_RELOAD_LOW, {24'h0, t[23:16]}, OK);
         wr(ETT_OFF_RELOAD_MID, {24'h0, t[15:8]}, OK);
         wr(ETT_OFF_STATUS, 32'h3, OK);
         wr(ETT_OFF_CONFIG, {24'h0, t[39:32]}, OK);
         ett_card_model_inst.start_bit();
         repeat (14 * ETU) @(posedge aclk);
         rd(ETT_OFF_STATUS, {24'h0, t[7:0]}, OK);
         wr(ETT_OFF_CONFIG, 32'h0, OK);
         rd(ETT_OFF_STATUS, {24'h0, t[7:0] & 8'h3}, OK);
      end
      end_of_test();
   end
endmodule : testbench
